// *** core/fpx_pkg.sv ***
// fpx_pkg: opcodes, return codes, sizes and carrier types of the flash command executor.
// assumes 32-bit command words, each split into a high and low 16-bit half.
package fpx_pkg;

  // opcodes in the upper half of the first word
  localparam logic [15:0] OP_MROW = 16'h0002;
  localparam logic [15:0] OP_WORD = 16'h0003;
  localparam logic [15:0] OP_ERASE_ALL = 16'h0004;
  localparam logic [15:0] OP_PAGE = 16'h0005;
  localparam logic [15:0] OP_BLANK = 16'h0006;

  // return codes in the lower half of an answer
  localparam logic [15:0] RC_OK = 16'h0000;
  localparam logic [15:0] RC_FAIL = 16'h0002;
  localparam logic [15:0] RC_UNK = 16'h0003;

  // sizes
  localparam int WORD_SHIFT = 2;
  localparam int ROW_BYTES = 512;
  localparam int ROW_WORDS = ROW_BYTES >> WORD_SHIFT;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] PAGE_BYTES = 32'h0000_0400;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;

  // controller states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ARGS = 6'h02,
    S_DATA = 6'h04,
    S_FOP = 6'h08,
    S_STEP = 6'h10,
    S_RESP = 6'h20
  } fpx_state_e;

  // operations asked of the flash array
  typedef enum logic [1:0] {
    FL_PROG = 2'h0,
    FL_ERASE_ALL = 2'h1,
    FL_ERASE_PAGE = 2'h2,
    FL_READ = 2'h3
  } fpx_flop_e;

  // one 32-bit word of command or answer
  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } fpx_word_s;

  // request held toward the flash array
  typedef struct packed {
    logic req;
    fpx_flop_e op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpx_fcmd_s;

endpackage : fpx_pkg

// *** core/fpx_skid.sv ***
// fpx_skid: two-entry buffer between the executor and the answer stream.
// assumes the receiver may hold ready low for any number of cycles.
`timescale 1ns/1ps
`default_nettype none
module fpx_skid
  import fpx_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic sk_valid; // second entry occupied
  logic [WIDTH-1:0] sk_data; // second entry word
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire stall = out_valid & ~out_ready;

  // full only when both entries hold a word
  assign in_ready = ~sk_valid;

  // head entry: refills from the second entry first to keep order
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop | ~out_valid)
    begin
      out_valid <= sk_valid | push;
      out_data <= sk_valid ? sk_data : in_data;
    end
  end

  // second entry catches a word pushed while the head stalls
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sk_valid <= 1'b0;
      sk_data <= '0;
    end
    else if (push & stall)
    begin
      sk_valid <= 1'b1;
      sk_data <= in_data;
    end
    else if (out_ready)
    begin
      sk_valid <= 1'b0;
    end
  end

  // a stalled word stays put until taken
  property p_hold;
    @(posedge mclk) disable iff (!arst_n)
    stall |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled answer changed");

  // a word pushed into a stalled head is kept, not dropped
  property p_keep;
    @(posedge mclk) disable iff (!arst_n)
    push && stall |=> sk_valid && sk_data == $past(in_data);
  endproperty
  a_keep: assert property (p_keep) else $error("pushed answer lost");

endmodule : fpx_skid
`default_nettype wire

// *** core/fpx_exec.sv ***
// fpx_exec: command executor between a probe word stream and the flash array.
// assumes flash answers each held request with a one-cycle fl_done, fl_fail and fl_rdata beside it.
`timescale 1ns/1ps
`default_nettype none
module fpx_exec
  import fpx_pkg::*;
#(
  parameter int ROWW = ROW_WORDS
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_data,
  input wire logic rsp_ready,
  output var fpx_fcmd_s fl_cmd,
  input wire logic fl_done,
  input wire logic fl_fail,
  input wire logic [31:0] fl_rdata,
  input wire logic global_code_protect_bit,
  input wire logic global_write_protect_bit
);

  localparam int PW = $clog2(ROWW);
  localparam logic [PW-1:0] LAST_POS = PW'(ROWW - 1);

  // opcode set that is answered; anything else is unknown
  function automatic logic is_known(input logic [15:0] op);
    is_known = (op == OP_MROW) || (op == OP_WORD) || (op == OP_ERASE_ALL)
               || (op == OP_PAGE) || (op == OP_BLANK);
  endfunction : is_known

  // flash operation used by each opcode
  function automatic fpx_flop_e flop_of(input logic [15:0] op);
    case (op)
      OP_ERASE_ALL: flop_of = FL_ERASE_ALL;
      OP_PAGE: flop_of = FL_ERASE_PAGE;
      OP_BLANK: flop_of = FL_READ;
      default: flop_of = FL_PROG;
    endcase
  endfunction : flop_of

  fpx_state_e state, next_state; // controller state
  logic [15:0] opc, next_opc; // opcode being served
  logic [15:0] hlen, next_hlen; // length half of header
  logic argi, next_argi; // second argument word due
  logic [31:0] addr, next_addr; // flash address in use
  logic [31:0] wdata, next_wdata; // word to program
  logic [31:0] cnt, next_cnt; // words or pages still to do
  logic [PW-1:0] wpos, next_wpos; // word within current row
  logic [15:0] blk, next_blk; // low address of current row
  logic pend, next_pend; // previous row awaits its answer
  logic [15:0] pend_addr, next_pend_addr; // low address of that row
  fpx_word_s out0, next_out0; // answer to push now
  fpx_word_s out1, next_out1; // answer to push after it
  logic out_two, next_out_two; // both answers queued
  logic ret_data, next_ret_data; // go back to data after answers

  // decoded helpers
  fpx_word_s cmd_w;
  assign cmd_w = fpx_word_s'(cmd_data);
  wire acc = cmd_valid & cmd_ready;
  wire buf_ready;
  wire push = (state == S_RESP) & buf_ready;
  wire [31:0] arg_words = cmd_data >> WORD_SHIFT;
  wire [15:0] rc_done = fl_fail ? RC_FAIL : RC_OK;
  wire row_end = (wpos == LAST_POS);
  wire last_item = (cnt == 32'h0000_0001);
  wire protect_ones = global_code_protect_bit & global_write_protect_bit;
  wire mrow_done = (state == S_FOP) & fl_done & (opc == OP_MROW);

  // answer stream passes a two-entry buffer so a stall loses nothing
  fpx_skid #(.WIDTH(32)) u_skid (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(state == S_RESP),
    .in_data(out0),
    .in_ready(buf_ready),
    .out_valid(rsp_valid),
    .out_data(rsp_data),
    .out_ready(rsp_ready)
  );

  // next-state and datapath decisions
  always_comb
  begin
    next_state = state;
    next_opc = opc;
    next_hlen = hlen;
    next_argi = argi;
    next_addr = addr;
    next_wdata = wdata;
    next_cnt = cnt;
    next_wpos = wpos;
    next_blk = blk;
    next_pend = pend;
    next_pend_addr = pend_addr;
    next_out0 = out0;
    next_out1 = out1;
    next_out_two = out_two;
    next_ret_data = ret_data;
    case (state)
      // header word: opcode above, length below
      S_IDLE:
        if (acc)
        begin
          next_opc = cmd_w.hi;
          next_hlen = cmd_w.lo;
          next_argi = 1'b0;
          next_out_two = 1'b0;
          next_ret_data = 1'b0;
          if (!is_known(cmd_w.hi))
          begin
            next_out0 = '{cmd_w.hi, RC_UNK};
            next_state = S_RESP;
          end
          else if (cmd_w.hi == OP_ERASE_ALL)
          begin
            next_state = S_FOP;
          end
          else
          begin
            next_state = S_ARGS;
          end
        end
      // argument words: address, then length or data; page erase takes the address only
      S_ARGS:
        if (acc && !argi)
        begin
          next_addr = cmd_data;
          if (opc != OP_PAGE)
          begin
            next_argi = 1'b1;
          end
          else if (hlen == 16'h0000)
          begin
            next_out0 = '{opc, RC_OK};
            next_state = S_RESP;
          end
          else
          begin
            // page count from the header; base alignment is the probe's job
            next_cnt = 32'(hlen);
            next_state = S_FOP;
          end
        end
        else if (acc)
        begin
          next_cnt = arg_words;
          if (opc == OP_WORD)
          begin
            next_wdata = cmd_data;
            next_state = S_FOP;
          end
          else if (opc == OP_MROW)
          begin
            // row alignment and whole rows are trusted from the probe
            next_wpos = '0;
            next_blk = addr[15:0];
            next_pend = 1'b0;
            next_out0 = '{addr[15:0], RC_OK};
            next_state = (arg_words == 32'h0000_0000) ? S_RESP : S_DATA;
          end
          else if (!protect_ones)
          begin
            next_out0 = '{opc, RC_FAIL};
            next_state = S_RESP;
          end
          else
          begin
            next_out0 = '{opc, RC_OK};
            next_state = (arg_words == 32'h0000_0000) ? S_RESP : S_FOP;
          end
        end
      // one data word of a row write
      S_DATA:
        if (acc)
        begin
          next_wdata = cmd_data;
          next_state = S_FOP;
        end
      // flash busy; act on its completion
      S_FOP:
        if (fl_done)
        begin
          next_state = S_RESP;
          next_out0 = '{opc, rc_done};
          next_cnt = cnt - 32'h0000_0001;
          if (opc == OP_PAGE && !fl_fail && !last_item)
          begin
            next_addr = addr + PAGE_BYTES;
            next_state = S_STEP;
          end
          else if (opc == OP_BLANK)
          begin
            next_addr = addr + WORD_BYTES;
            if (fl_rdata != ERASED_WORD)
            begin
              next_out0 = '{opc, RC_FAIL};
            end
            else if (!last_item)
            begin
              next_state = S_STEP;
            end
          end
          else if (opc == OP_MROW)
          begin
            next_addr = addr + WORD_BYTES;
            next_wpos = wpos + 1'b1;
            next_out0 = '{blk, rc_done};
            next_ret_data = 1'b0;
            if (fl_fail || (row_end && last_item))
            begin
              // older row answered first; failure ends the command
              next_out_two = pend;
              next_out0 = pend ? fpx_word_s'{pend_addr, RC_OK} : fpx_word_s'{blk, rc_done};
              next_out1 = '{blk, rc_done};
            end
            else if (row_end)
            begin
              // row done: previous row is answered, this one waits
              next_pend = 1'b1;
              next_pend_addr = blk;
              next_blk = next_addr[15:0];
              next_out0 = '{pend_addr, RC_OK};
              next_ret_data = 1'b1;
              next_state = pend ? S_RESP : S_DATA;
            end
            else
            begin
              next_state = S_DATA;
            end
          end
        end
      // one idle cycle drops the request between loop steps
      S_STEP:
        next_state = S_FOP;
      // push queued answers into the buffer
      S_RESP:
        if (push && out_two)
        begin
          next_out0 = out1;
          next_out_two = 1'b0;
        end
        else if (push)
        begin
          next_state = ret_data ? S_DATA : S_IDLE;
        end
      default:
        next_state = S_IDLE;
    endcase
  end

  // controller registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= S_IDLE;
      {opc, hlen, argi, addr, wdata, cnt, wpos} <= '0;
      {blk, pend, pend_addr, out0, out1, out_two, ret_data} <= '0;
    end
    else
    begin
      state <= next_state;
      {opc, hlen, argi, addr, wdata, cnt, wpos} <= {next_opc, next_hlen, next_argi, next_addr,
        next_wdata, next_cnt, next_wpos};
      {blk, pend, pend_addr, out0, out1, out_two, ret_data} <= {next_blk, next_pend,
        next_pend_addr, next_out0, next_out1, next_out_two, next_ret_data};
    end
  end

  // outputs registered from next state so they line up with it
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_ready <= 1'b0;
      fl_cmd <= '0;
    end
    else
    begin
      cmd_ready <= (next_state == S_IDLE) || (next_state == S_ARGS) || (next_state == S_DATA);
      fl_cmd <= '{next_state == S_FOP, flop_of(next_opc), next_addr, next_wdata};
    end
  end

  property p_unknown;
    @(posedge mclk) disable iff (!arst_n)
    state == S_IDLE && acc && !is_known(cmd_w.hi) |=> state == S_RESP && out0 == {$past(cmd_w.hi), RC_UNK};
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown opcode not refused");

  property p_tag;
    @(posedge mclk) disable iff (!arst_n)
    push && opc != OP_MROW |-> out0.hi == opc;
  endproperty
  a_tag: assert property (p_tag) else $error("answer lacks opcode");

  property p_fail_stop;
    @(posedge mclk) disable iff (!arst_n)
    mrow_done && fl_fail |=> state == S_RESP && !cmd_ready && !ret_data ##1 state != S_DATA;
  endproperty
  a_fail_stop: assert property (p_fail_stop) else $error("data taken after failure");

  property p_first_row;
    @(posedge mclk) disable iff (!arst_n)
    mrow_done && !fl_fail && row_end && !last_item && !pend |=> state == S_DATA && pend;
  endproperty
  a_first_row: assert property (p_first_row) else $error("first row answered early");

  property p_two_rows;
    @(posedge mclk) disable iff (!arst_n)
    mrow_done && !fl_fail && row_end && last_item && pend |=> out_two && out0.hi == $past(pend_addr)
      && out1.hi == $past(blk);
  endproperty
  a_two_rows: assert property (p_two_rows) else $error("final answers out of order");

  property p_one_row;
    @(posedge mclk) disable iff (!arst_n)
    mrow_done && row_end && last_item && !pend |=> state == S_RESP && !out_two;
  endproperty
  a_one_row: assert property (p_one_row) else $error("single row answer wrong");

  property p_erase_all;
    @(posedge mclk) disable iff (!arst_n)
    state == S_IDLE && acc && cmd_w.hi == OP_ERASE_ALL |=> fl_cmd.req && fl_cmd.op == FL_ERASE_ALL;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("full erase not issued");

  property p_page_step;
    @(posedge mclk) disable iff (!arst_n)
    state == S_FOP && fl_done && opc == OP_PAGE && !fl_fail && !last_item |=> !fl_cmd.req
      && fl_cmd.addr == $past(fl_cmd.addr) + PAGE_BYTES ##1 fl_cmd.req;
  endproperty
  a_page_step: assert property (p_page_step) else $error("page stride wrong");

  property p_blank_fail;
    @(posedge mclk) disable iff (!arst_n)
    state == S_FOP && fl_done && opc == OP_BLANK && fl_rdata != ERASED_WORD |=> state == S_RESP
      && out0.lo == RC_FAIL;
  endproperty
  a_blank_fail: assert property (p_blank_fail) else $error("non-blank word passed");

  property p_word_rc;
    @(posedge mclk) disable iff (!arst_n)
    state == S_FOP && fl_done && opc == OP_WORD |=> out0.lo == ($past(fl_fail) ? RC_FAIL : RC_OK);
  endproperty
  a_word_rc: assert property (p_word_rc) else $error("word write status wrong");

endmodule : fpx_exec
`default_nettype wire

// *** tb/fpx_flash_model.sv ***
// fpx_flash_model: behavioural flash array answering the executor's held requests.
// assumes one request at a time; unwritten words read as erased.
`timescale 1ns/1ps
`default_nettype none
module fpx_flash_model
  import fpx_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire fpx_fcmd_s fl_cmd,
  input wire logic slow,
  input wire logic fail_en,
  input wire logic [31:0] fail_addr,
  output logic fl_done,
  output logic fl_fail,
  output logic [31:0] fl_rdata
);
  logic [31:0] mem [logic [31:0]]; // sparse, absent means erased
  int wait_cnt; // cycles spent on the held request
  logic hit; // held request is the one chosen to fail
  assign hit = fail_en && (fl_cmd.addr == fail_addr);

  // bench read-back, absent words are erased
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : ERASED_WORD;
  endfunction : peek

  // one done pulse per request, after one or five idle cycles
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fl_done <= 1'b0;
      fl_fail <= 1'b0;
      fl_rdata <= 32'h0;
      wait_cnt <= 0;
    end
    else
    begin
      fl_done <= 1'b0;
      fl_fail <= 1'b0;
      fl_rdata <= ~fl_rdata; // stale data keeps changing, never trusted
      // the done edge itself still sees req high, so skip it
      if (fl_cmd.req && !fl_done)
      begin
        if (wait_cnt < (slow ? 5 : 1))
          wait_cnt <= wait_cnt + 1;
        else
        begin
          wait_cnt <= 0;
          fl_done <= 1'b1;
          fl_fail <= hit;
          // a failed program leaves the word as it was
          if (fl_cmd.op == FL_PROG && !hit)
            mem[fl_cmd.addr] = fl_cmd.wdata;
          if (fl_cmd.op == FL_ERASE_ALL)
            mem.delete();
          if (fl_cmd.op == FL_ERASE_PAGE)
            for (int i = 0; i < (PAGE_BYTES >> WORD_SHIFT); i++)
              mem.delete(fl_cmd.addr + 32'(4 * i));
          if (fl_cmd.op == FL_READ)
            fl_rdata <= peek(fl_cmd.addr);
        end
      end
    end
  end
endmodule : fpx_flash_model
`default_nettype wire

// *** tb/tb.sv ***
// tb: self-checking bench for the flash command executor with a flash model behind it.
// assumes answers are collected whenever rsp_valid and rsp_ready meet at an edge.
`timescale 1ns/1ps
`default_nettype none
module tb
  import fpx_pkg::*;
;
  logic mclk, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic [31:0] cmd_data, rsp_data, fl_rdata, fail_addr;
  fpx_fcmd_s fl_cmd; // request toward the flash model
  logic fl_done, fl_fail, slow, fail_en;
  logic global_code_protect_bit, global_write_protect_bit;
  logic rsp_hold, rsp_slow; // receiver stall controls
  logic [7:0] cyc = 8'h0; // stall pattern source
  logic [31:0] rq[$]; // answers taken so far
  int failures = 0;
  int checked = 0;

  fpx_exec uut (.mclk(mclk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .fl_cmd(fl_cmd), .fl_done(fl_done), .fl_fail(fl_fail), .fl_rdata(fl_rdata),
    .global_code_protect_bit(global_code_protect_bit),
    .global_write_protect_bit(global_write_protect_bit));

  fpx_flash_model flash (.mclk(mclk), .arst_n(arst_n), .fl_cmd(fl_cmd), .slow(slow),
    .fail_en(fail_en), .fail_addr(fail_addr), .fl_done(fl_done), .fl_fail(fl_fail),
    .fl_rdata(fl_rdata));

  // clock, 40 ns period
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // receiver: ready unless held, or stalls half the time
  always @(posedge mclk)
  begin
    cyc <= cyc + 8'h1;
    rsp_ready <= #1 !rsp_hold && !(rsp_slow && cyc[1]);
  end

  // collect every answer taken
  always @(posedge mclk)
    if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
      rq.push_back(rsp_data);

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cycles

  // offer one word, held until taken; valid stays up for back to back words
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_data = w;
    @(posedge mclk);
    while (cmd_ready !== 1'b1 && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    #1;
    if (n >= 4000)
      chk(32'h0, 32'h1);
  endtask : send

  // drop valid and let an edge pass before anything new
  task automatic release_cmd();
    cmd_valid = 1'b0;
    wait_cycles(1);
  endtask : release_cmd

  task automatic expect_rsp(input logic [31:0] exp);
    int n;
    n = 0;
    while (rq.size() == 0 && n < 4000)
    begin
      wait_cycles(1);
      n++;
    end
    if (rq.size() == 0)
      chk(32'hdead_0000, exp);
    else
      chk(rq.pop_front(), exp);
  endtask : expect_rsp

  task automatic t_word(input logic [31:0] a, input logic [31:0] d);
    send({OP_WORD, 16'h0002});
    send(a);
    send(d);
    release_cmd();
    expect_rsp({OP_WORD, RC_OK});
    chk(flash.peek(a), d);
  endtask : t_word

  // word write onto the address chosen to fail: failure code, word left erased
  task automatic t_word_fail(input logic [31:0] a);
    send({OP_WORD, 16'h0002});
    send(a);
    send(32'h5a5a_a5a5);
    release_cmd();
    expect_rsp({OP_WORD, RC_FAIL});
    chk(flash.peek(a), ERASED_WORD);
  endtask : t_word_fail

  // three unknown headers while the receiver stalls: buffer fills and refuses
  task automatic t_unknown();
    rsp_hold = 1'b1;
    wait_cycles(1);
    send(32'h0010_0000);
    send(32'habcd_0005);
    send(32'h00ff_0000);
    release_cmd();
    wait_cycles(8);
    chk({31'h0, cmd_ready}, 32'h0);
    chk(rsp_data, {16'h0010, RC_UNK});
    rsp_hold = 1'b0;
    expect_rsp({16'h0010, RC_UNK});
    expect_rsp({16'habcd, RC_UNK});
    expect_rsp({16'h00ff, RC_UNK});
  endtask : t_unknown

  task automatic t_erase_all(input logic [31:0] a);
    t_word(a, 32'h0);
    send({OP_ERASE_ALL, 16'h1234});
    release_cmd();
    expect_rsp({OP_ERASE_ALL, RC_OK});
    chk(flash.peek(a), ERASED_WORD);
  endtask : t_erase_all

  task automatic t_blank(input logic [31:0] a, input logic [31:0] len, input logic cp, input logic wp,
    input logic [15:0] rc);
    global_code_protect_bit = cp;
    global_write_protect_bit = wp;
    send({OP_BLANK, 16'h0000});
    send(a);
    send(len);
    release_cmd();
    expect_rsp({OP_BLANK, rc});
    global_code_protect_bit = 1'b1;
    global_write_protect_bit = 1'b1;
  endtask : t_blank

  // two pages from 0x400: neighbours on both sides must survive
  task automatic t_page();
    t_word(32'h0000_03fc, 32'h0);
    t_word(32'h0000_0bfc, 32'h1);
    t_word(32'h0000_0c00, 32'h2);
    send({OP_PAGE, 16'h0002});
    send(32'h0000_0400);
    release_cmd();
    expect_rsp({OP_PAGE, RC_OK});
    chk(flash.peek(32'h0000_0bfc), ERASED_WORD);
    chk(flash.peek(32'h0000_03fc), 32'h0);
    chk(flash.peek(32'h0000_0c00), 32'h2);
  endtask : t_page

  // rows sent one by one; the probe stops after the failing row
  task automatic t_mrow(input logic [31:0] base, input int rows, input int bad);
    logic [31:0] a;
    send({OP_MROW, 16'h0000});
    send(base);
    send(32'(rows * ROW_BYTES));
    for (int r = 0; r < rows && r <= bad; r++)
    begin
      for (int i = 0; i < ROW_WORDS; i++)
        send((base + 32'(r * ROW_BYTES + 4 * i)) ^ 32'h5a5a_0000);
      release_cmd();
      wait_cycles(16);
      if (r < rows - 1 && r < bad)
        chk(32'(rq.size()), 32'(r));
    end
    for (int r = 0; r < rows && r <= bad; r++)
    begin
      a = base + 32'(r * ROW_BYTES);
      expect_rsp({a[15:0], (r == bad) ? RC_FAIL : RC_OK});
      if (r != bad)
        chk(flash.peek(a + 32'h1fc), (a + 32'h1fc) ^ 32'h5a5a_0000);
    end
    wait_cycles(16);
    chk(32'(rq.size()), 32'h0);
    // read back the failing row and locate the bad word
    a = base + 32'(bad * ROW_BYTES);
    if (bad < rows)
      for (int i = 0; i < ROW_WORDS; i++)
        if (flash.peek(a + 32'(4 * i)) !== ((a + 32'(4 * i)) ^ 32'h5a5a_0000))
          chk(a + 32'(4 * i), fail_addr);
  endtask : t_mrow

  // watchdog, well beyond the expected run
  initial
  begin
    #(40 * 60000);
    failures++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end

  // main sequence
  initial
  begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_data = 32'h0;
    rsp_hold = 1'b0;
    rsp_slow = 1'b0;
    slow = 1'b0;
    fail_en = 1'b0;
    fail_addr = 32'h0;
    global_code_protect_bit = 1'b1;
    global_write_protect_bit = 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    wait_cycles(2);
    t_word(32'h0000_0100, 32'h1234_5678);
    t_unknown();
    t_erase_all(32'h0000_0100);
    t_blank(32'h0, 32'h10, 1'b1, 1'b1, RC_OK);
    t_blank(32'h0, 32'h10, 1'b0, 1'b1, RC_FAIL);
    t_blank(32'h0, 32'h10, 1'b1, 1'b0, RC_FAIL);
    t_word(32'h0000_0008, 32'h0);
    t_blank(32'h0, 32'h10, 1'b1, 1'b1, RC_FAIL);
    t_blank(32'h10, 32'h8, 1'b1, 1'b1, RC_OK);
    t_page();
    slow = 1'b1;
    rsp_slow = 1'b1;
    t_mrow(32'h0000_1000, 1, 9);
    t_mrow(32'h0001_2000, 2, 9);
    t_mrow(32'h0002_4000, 3, 9);
    fail_addr = 32'h0003_83fc;
    fail_en = 1'b1;
    t_mrow(32'h0003_8000, 3, 1);
    t_word_fail(32'h0003_83fc);
    fail_en = 1'b0;
    t_word(32'h0000_0200, 32'hcafe_0001);
    conclude();
  end
endmodule : tb
`default_nettype wire
